// ===== logic/imuspi_port.sv
// serial slave port, sample-clock input and data-ready output of the sensor
// assumes serial clock, select, data input and pin four are asynchronous pins
//
// Function
// - shift next output bit on falling clock
// - sample input bit on rising clock
// - data ready about 600 us after sync
// - pin four is gpio or sample clock
// - period setting selects normal or low power
// - mode 3, 16-bit frames, msb first
// - read address frame, data next frame
`timescale 1ns/1ns
module imuspi_port
   import imuspi_pkg::*;
#(
   parameter int SYNC_DELAY_CYC = SYNC_TO_READY_CYC
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic dout,
   input wire logic gp_pin_four_or_sample_clock_in,
   output logic gp_pin_four_or_sample_clock_out,
   output logic gp_pin_four_or_sample_clock_oe,
   input wire logic sample_clock_select,
   input wire logic gpio_dir_out,
   input wire logic gpio_out_value,
   output logic gpio_in_value,
   input wire logic [7:0] sample_period_setting,
   output logic low_power_mode,
   output imuspi_req_t reg_req,
   input wire logic [15:0] reg_rdata,
   output logic data_ready
);

   if (SYNC_DELAY_CYC < 1) begin : g_bad_delay
      $error("sync delay must be at least one cycle");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sclk_sy_ff, cs_sy_ff, din_sy_ff, p4_sy_ff;
   logic sclk_d_ff, p4_d_ff;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_sy_ff <= 2'h3;
         cs_sy_ff <= 2'h3;
         din_sy_ff <= 2'h0;
         p4_sy_ff <= 2'h0;
         sclk_d_ff <= 1'b1;
         p4_d_ff <= 1'b0;
      end else begin
         sclk_sy_ff <= {sclk_sy_ff[0], sclk};
         cs_sy_ff <= {cs_sy_ff[0], cs_n};
         din_sy_ff <= {din_sy_ff[0], din};
         p4_sy_ff <= {p4_sy_ff[0], gp_pin_four_or_sample_clock_in};
         sclk_d_ff <= sclk_sy_ff[1];
         p4_d_ff <= p4_sy_ff[1];
      end
   end

   logic sclk_rise, sclk_fall, frame_on, sync_rise;
   assign frame_on = !cs_sy_ff[1];
   assign sclk_rise = frame_on && sclk_sy_ff[1] && !sclk_d_ff;
   assign sclk_fall = frame_on && !sclk_sy_ff[1] && sclk_d_ff;

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   imuspi_mode_t mode_ff;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_ff <= IMUSPI_MODE_NORMAL;
      end else if (sample_period_setting <= NORMAL_PERIOD_MAX) begin
         mode_ff <= IMUSPI_MODE_NORMAL;
      end else begin
         mode_ff <= IMUSPI_MODE_LOW_POWER;
      end
   end
   // low power is the only mode code with bit 0 set, so the pin is a flop bit
   assign low_power_mode = mode_ff[0];

   // ----------------------------------------------------------------
   // frame shifter
   // ----------------------------------------------------------------
   logic [15:0] rx_ff, tx_ff;
   logic [4:0] bit_cnt_ff;
   logic rd_pend_ff, cs_d_ff;
   logic [15:0] nxt_rx;
   assign nxt_rx = {rx_ff[14:0], din_sy_ff[1]};

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rx_ff <= 16'h0000;
         bit_cnt_ff <= 5'h00;
         cs_d_ff <= 1'b1;
      end else begin
         cs_d_ff <= cs_sy_ff[1];
         if (!frame_on) begin
            bit_cnt_ff <= 5'h00;
         end else if (sclk_rise) begin
            rx_ff <= nxt_rx;
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
         end
      end
   end

   // write request issued on the sixteenth rising edge of the frame
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_req <= '0;
         rd_pend_ff <= 1'b0;
      end else begin
         reg_req.valid <= 1'b0;
         if (sclk_rise && bit_cnt_ff == 5'(FRAME_BITS - 1)) begin
            reg_req.valid <= nxt_rx[WRITE_FLAG_POS];
            reg_req.write <= nxt_rx[WRITE_FLAG_POS];
            reg_req.addr <= nxt_rx[ADDR_MSB:ADDR_LSB];
            reg_req.data <= nxt_rx[7:0];
            rd_pend_ff <= !nxt_rx[WRITE_FLAG_POS];
         end
      end
   end

   // read data is shifted out in the frame after the address frame;
   // the msb sits on dout from select fall, the rest follow falling edges
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tx_ff <= 16'h0000;
         dout <= 1'b0;
      end else begin
         if (cs_d_ff && frame_on) begin
            tx_ff <= rd_pend_ff ? reg_rdata : 16'h0000;
            dout <= rd_pend_ff ? reg_rdata[15] : 1'b0;
         end else if (sclk_fall && bit_cnt_ff != 5'h00) begin
            tx_ff <= {tx_ff[14:0], 1'b0};
            dout <= tx_ff[14];
         end
      end
   end

   // ----------------------------------------------------------------
   // pin four: gpio or sample clock
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gp_pin_four_or_sample_clock_oe <= 1'b0;
         gp_pin_four_or_sample_clock_out <= 1'b0;
         gpio_in_value <= 1'b0;
      end else begin
         gp_pin_four_or_sample_clock_oe <= !sample_clock_select && gpio_dir_out;
         gp_pin_four_or_sample_clock_out <= gpio_out_value;
         gpio_in_value <= p4_sy_ff[1];
      end
   end
   assign sync_rise = sample_clock_select && p4_sy_ff[1] && !p4_d_ff;

   // ----------------------------------------------------------------
   // sync to data ready
   // ----------------------------------------------------------------
   // a new sync edge while one is pending restarts the delay; the source
   // period limit keeps that from happening in legal use
   logic [$clog2(SYNC_DELAY_CYC+1)-1:0] dly_ff;
   logic dly_run_ff;
   logic [4:0] rdy_cnt_ff;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dly_ff <= '0;
         dly_run_ff <= 1'b0;
         rdy_cnt_ff <= 5'h00;
         data_ready <= 1'b0;
      end else begin
         // countdown first, so a reload in the same cycle wins
         if (rdy_cnt_ff != 5'h00) begin
            rdy_cnt_ff <= rdy_cnt_ff - 5'h01;
         end
         if (sync_rise) begin
            dly_ff <= '0;
            dly_run_ff <= 1'b1;
         end else if (dly_run_ff) begin
            dly_ff <= dly_ff + 1'b1;
            if (dly_ff == ($bits(dly_ff))'(SYNC_DELAY_CYC - 1)) begin
               dly_run_ff <= 1'b0;
               rdy_cnt_ff <= 5'(READY_PULSE_CYC);
            end
         end
         data_ready <= (rdy_cnt_ff != 5'h00);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_rise_sample;
      @(posedge clk_sys) disable iff (rst)
      sclk_rise |=> rx_ff[0] == $past(din_sy_ff[1]);
   endproperty
   a_rise_sample: assert property (p_rise_sample) else $error("input not sampled");

   property p_fall_shift;
      @(posedge clk_sys) disable iff (rst)
      (sclk_fall && bit_cnt_ff != 5'h00 && !(cs_d_ff && frame_on))
         |=> dout == $past(tx_ff[14]);
   endproperty
   a_fall_shift: assert property (p_fall_shift) else $error("output not shifted");

   property p_dout_stable;
      @(posedge clk_sys) disable iff (rst)
      (frame_on && !sclk_fall && !cs_d_ff) |=> $stable(dout);
   endproperty
   a_dout_stable: assert property (p_dout_stable) else $error("dout moved off edge");

   property p_mode;
      @(posedge clk_sys) disable iff (rst)
      ##1 low_power_mode == ($past(sample_period_setting) > NORMAL_PERIOD_MAX);
   endproperty
   a_mode: assert property (p_mode) else $error("wrong mode");

   property p_oe;
      @(posedge clk_sys) disable iff (rst)
      sample_clock_select |=> !gp_pin_four_or_sample_clock_oe;
   endproperty
   a_oe: assert property (p_oe) else $error("pin four driven as clock");

   property p_ready;
      @(posedge clk_sys) disable iff (rst)
      (dly_run_ff && dly_ff == ($bits(dly_ff))'(SYNC_DELAY_CYC - 1) && !sync_rise)
         |=> ##1 data_ready;
   endproperty
   a_ready: assert property (p_ready) else $error("data ready late");

   property p_req;
      @(posedge clk_sys) disable iff (rst)
      reg_req.valid |-> reg_req.write && $past(bit_cnt_ff) == 5'(FRAME_BITS - 1);
   endproperty
   a_req: assert property (p_req) else $error("write request off frame end");

   property p_rd_load;
      @(posedge clk_sys) disable iff (rst)
      (cs_d_ff && frame_on && rd_pend_ff) |=> tx_ff == $past(reg_rdata);
   endproperty
   a_rd_load: assert property (p_rd_load) else $error("read data not loaded");

endmodule

// ===== logic/imuspi_pkg.sv
// package for the inertial sensor serial slave port and sync-clock input
// assumes a 125 MHz system clock; all times are converted to cycles here
package imuspi_pkg;

   // ----------------------------------------------------------------
   // clock and timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   // typical sync edge to data ready, microseconds
   localparam int SYNC_TO_READY_US = 600;
   localparam int SYNC_TO_READY_CYC = SYNC_TO_READY_US * 1000 / CLK_PERIOD_NS;
   // shortest high pulse the sync source must hold, microseconds
   localparam int SYNC_HIGH_MIN_US = 5;
   localparam int SYNC_HIGH_MIN_CYC = (SYNC_HIGH_MIN_US * 1000 + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // length of the data-ready pulse, in cycles
   localparam int READY_PULSE_CYC = 16;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int WRITE_FLAG_POS = 15;
   localparam int ADDR_MSB = 14;
   localparam int ADDR_LSB = 8;
   localparam int ADDR_W = 7;

   // ----------------------------------------------------------------
   // mode selection
   // ----------------------------------------------------------------
   localparam logic [7:0] NORMAL_PERIOD_MAX = 8'h09;
   localparam logic [7:0] SAMPLE_PERIOD_RESET = 8'h01;

   typedef enum logic [1:0] {
      IMUSPI_MODE_NORMAL = 2'b00,
      IMUSPI_MODE_LOW_POWER = 2'b01
   } imuspi_mode_t;

   // request to the register file behind the port
   typedef struct packed {
      logic valid;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } imuspi_req_t;

endpackage

// ===== test/imuspi_master.sv
// serial bus master and sync-clock source facing the sensor port
// assumes the bench calls frame and sync_pulse one at a time
`timescale 1ns/1ns
module imuspi_master (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   output logic sync_out
);
   // bench rate is far above the pin limit to keep runs short
   localparam int HALF_NS = 32;
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
      sync_out = 1'b0;
   end
   // ------------------------------------------------
   // one frame, msb first; dout read late in high phase
   // ------------------------------------------------
   task automatic frame(input logic [15:0] tx, input int nbits, input int gap_us,
      output logic [15:0] rx);
      rx = '0;
      cs_n = 1'b0;
      #64;
      for (int i = 15; i > 15 - nbits; i--) begin
         sclk = 1'b0;
         din = tx[i];
         #HALF_NS;
         sclk = 1'b1;
         #HALF_NS;
         rx = {rx[14:0], dout};
      end
      #16;
      cs_n = 1'b1;
      din = ~din;  // a released line must not look like the last bit
      #(gap_us * 1000);
   endtask
   task automatic sync_pulse();
      sync_out = 1'b1;
      #5000;
      sync_out = 1'b0;
      #100000;
   endtask
endmodule

// ===== test/tb.sv
// self-checking bench for the serial port, pin four and data-ready output
// assumes the master model drives the serial pins asynchronously
`timescale 1ns/1ns
module tb;
   import imuspi_pkg::*;
   localparam int SYNC = 50;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic sclk, cs_n, din, dout, p4_out, p4_oe, sync_out, gp_in, lp, data_ready;
   logic sel = 1'b0, dir_out = 1'b0, out_val = 1'b0, gp_drive = 1'b0;
   logic [7:0] period = 8'h01;
   logic [7:0] mv [4] = '{8'h09, 8'h0a, 8'h00, 8'hff};
   logic [15:0] rdata = 16'h0000, tx, rx, exp_rx;
   imuspi_req_t req, last_req;
   int errors = 0, cmp_count = 0, nreq = 0, n, w;
   wire logic p4 = p4_oe ? p4_out : (sync_out | gp_drive);
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   imuspi_master m (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .sync_out(sync_out));
   imuspi_port #(.SYNC_DELAY_CYC(SYNC)) uut (.clk_sys(clk_sys), .rst(rst), .sclk(sclk),
      .cs_n(cs_n), .din(din), .dout(dout), .gp_pin_four_or_sample_clock_in(p4),
      .gp_pin_four_or_sample_clock_out(p4_out), .gp_pin_four_or_sample_clock_oe(p4_oe),
      .sample_clock_select(sel), .gpio_dir_out(dir_out), .gpio_out_value(out_val),
      .gpio_in_value(gp_in), .sample_period_setting(period), .low_power_mode(lp),
      .reg_req(req), .reg_rdata(rdata), .data_ready(data_ready));
   always @(posedge clk_sys) begin
      if (req.valid === 1'b1) begin
         nreq <= nreq + 1;
         last_req <= req;
      end
   end
   // ------------------------------------------------
   // compare and close
   // ------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic settle(input int c);
      repeat (c) @(negedge clk_sys);
   endtask
   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      void'($urandom(32'h52ee));
      settle(10);
      chk({dout, p4_oe, p4_out, data_ready, lp, req}, '0);
      settle(2);
      rst = 1'b0;
      settle(4);
      for (int k = 0; k < 5; k++) begin
         period = (k < 4) ? mv[k] : 8'($urandom);
         settle(3);
         chk(lp, period > NORMAL_PERIOD_MAX);
      end
      period = 8'h01;
      dir_out = 1'b1;
      out_val = 1'b1;
      settle(4);
      chk({p4_oe, p4_out}, 2'b11);
      out_val = 1'b0;
      settle(4);
      chk({p4_oe, p4_out}, 2'b10);
      dir_out = 1'b0;
      gp_drive = 1'b1;
      settle(4);
      chk({p4_oe, gp_in}, 2'b01);
      gp_drive = 1'b0;
      sel = 1'b1;
      dir_out = 1'b1;
      settle(4);
      chk(p4_oe, 1'b0);
      fork
         m.sync_pulse();
         begin
            // sync_out rises in this time step; count from here
            w = 0;
            while (data_ready !== 1'b1 && w < 200) begin
               @(negedge clk_sys);
               w++;
            end
            chk(w >= SYNC + 2 && w <= SYNC + 6, 1'b1);
            if (w == 200) begin
               report_and_stop();
            end else begin
               w = 0;
               while (data_ready === 1'b1 && w < 100) begin
                  @(negedge clk_sys);
                  w++;
               end
               chk(w, READY_PULSE_CYC);
            end
         end
      join
      // random frames; two reads back to back, low power, then a short frame
      for (int k = 0; k < 8; k++) begin
         tx = 16'($urandom);
         if (k == 1 || k == 2) tx[15] = 1'b0;
         if (k == 5) period = 8'h0a;
         exp_rx = rdata;
         n = nreq;
         m.frame(tx, (k == 6) ? 8 : 16, (period > NORMAL_PERIOD_MAX) ? 100 : 40, rx);
         if ((k == 2 || k == 3) && k != 6) chk(rx, exp_rx);
         chk(nreq, n + ((tx[15] && k != 6) ? 1 : 0));
         if (tx[15] && k != 6) chk(last_req, {2'b11, tx[14:0]});
         @(negedge clk_sys);
         rdata = 16'($urandom);
      end
      report_and_stop();
   end
endmodule
